// ---- logic/tcs_xcvr_ctrl.sv ----
// Overview of operation
// - A rising transmit-off pin turns the laser off within 10 us.
// - A falling transmit-off pin restores the laser within 1 ms.
// - After power-on the block is initialised, fault cleared, within 300 ms.
// - Holding the transmit-off pin high for 10 us clears the latched laser fault.
// - Loss of optical signal drops the signal-presence pin within 100 us.
// - A valid optical signal raises the signal-presence pin within 100 us.
// - Setting bit 6 of byte 110 turns the laser off within 100 ms of the write.
// - Clearing bit 6 of byte 110 restores the laser within 100 ms.
// - A transmitter fault sets bit 2 of byte 110 within 100 ms.
// - Bit 1 of byte 110 follows signal presence within 100 ms either way.
// - Bit 0 of byte 110 is set within 1000 ms of power-on.
// - The serial bus answers both device addresses within 300 ms of power-on.
// - A serial write of one to eight bytes takes effect within 10 ms of the stop.
module tcs_xcvr_ctrl #(
  parameter int unsigned INIT_CYC = tcs_pkg::INIT_CYC_DEF
) (
  // Clock and power-on reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Transmitter pins and laser
  input  wire logic tx_disable_i,
  input  wire logic laser_fault_i,
  output wire logic laser_en_o,
  output wire logic tx_fault_o,
  // Receiver
  input  wire logic rx_signal_i,
  output wire logic sig_det_o,
  // Two-wire serial bus
  input  wire logic scl_i,
  input  wire logic sda_i,
  output wire logic sda_o,
  output wire logic sda_oe_o,
  output wire logic serial_ready_o
);

  typedef struct packed {
    logic                scl_s1;
    logic                scl_s2;
    logic                scl_s3;
    logic                sda_s1;
    logic                sda_s2;
    logic                sda_s3;
    logic                dis_s1;
    logic                dis_s2;
    logic                flt_s1;
    logic                flt_s2;
    logic                sig_s1;
    logic                sig_s2;
    logic [31:0]         init_cnt;
    logic                init_done;
    logic                fault;
    logic                soft_dis;
    logic                laser_en;
    tcs_pkg::tcs_state_t state;
    tcs_pkg::tcs_state_t ack_from;
    logic [2:0]          cnt;
    logic                done;
    logic [7:0]          shreg;
    logic [7:0]          ptr;
    logic                sel_diag;
    logic                rd;
    logic                sda_drv;
    logic                wr_pend;
    logic                wr_val;
  } tcs_ctrl_st_t;

  tcs_ctrl_st_t q;
  tcs_ctrl_st_t d;

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic [7:0] status;

  tcs_hold_if hold_dis ();

  // ------------------------------------------------------------------
  // Fault-clear qualifier on the transmit-off pin
  // ------------------------------------------------------------------
  assign hold_dis.level = q.dis_s2;

  tcs_hold_timer #(
    .N (tcs_pkg::RESET_HOLD_CYC)
  ) u_hold_dis (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .hold      (hold_dis)
  );

  // ------------------------------------------------------------------
  // Bus conditions from synchronised lines
  // ------------------------------------------------------------------
  assign scl_rise  = q.scl_s2 & ~q.scl_s3;
  assign scl_fall  = ~q.scl_s2 & q.scl_s3;
  assign bus_start = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
  assign bus_stop  = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;

  always_comb begin
    status                        = 8'h00;
    status[tcs_pkg::BIT_HARD_DIS] = q.dis_s2;
    status[tcs_pkg::BIT_SOFT_DIS] = q.soft_dis;
    status[tcs_pkg::BIT_FAULT]    = q.fault;
    status[tcs_pkg::BIT_SIGDET]   = q.sig_s2;
    status[tcs_pkg::BIT_READY]    = q.init_done;
  end

  function automatic logic [7:0] rd_byte(input logic       sel,
                                         input logic [7:0] ptr,
                                         input logic [7:0] stat);
    rd_byte = tcs_pkg::UNMAPPED_DATA;
    if (sel && ptr == tcs_pkg::DIAG_CTRL_OFS) begin
      rd_byte = stat;
    end
  endfunction : rd_byte

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    d        = q;
    d.scl_s1 = scl_i;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = sda_i;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.dis_s1 = tx_disable_i;
    d.dis_s2 = q.dis_s1;
    d.flt_s1 = laser_fault_i;
    d.flt_s2 = q.flt_s1;
    d.sig_s1 = rx_signal_i;
    d.sig_s2 = q.sig_s1;

    // Power-on initialisation
    if (!q.init_done) begin
      d.fault = 1'b0;
      if (q.init_cnt == INIT_CYC - 1) begin
        d.init_done = 1'b1;
      end else begin
        d.init_cnt = q.init_cnt + 32'h1;
      end
    end else begin
      // A fault present in the clearing cycle still latches
      if (hold_dis.done) begin
        d.fault = 1'b0;
      end
      if (q.flt_s2) begin
        d.fault = 1'b1;
      end
    end

    // Any off source (pin, soft bit, fault or unfinished init) keeps the laser dark
    d.laser_en = q.init_done & ~q.dis_s2 & ~q.soft_dis & ~q.fault;

    // Serial slave
    // Traffic before initialisation ends is ignored
    if (!q.init_done) begin
      d.state   = tcs_pkg::TCS_IDLE;
      d.sda_drv = 1'b0;
    end else if (bus_start) begin
      d.state   = tcs_pkg::TCS_ADDR;
      d.cnt     = 3'd0;
      d.done    = 1'b0;
      d.sda_drv = 1'b0;
    end else if (bus_stop) begin
      if (q.wr_pend) begin
        d.soft_dis = q.wr_val;
        d.wr_pend  = 1'b0;
      end
      d.state   = tcs_pkg::TCS_IDLE;
      d.sda_drv = 1'b0;
      d.done    = 1'b0;
    end else begin
      case (q.state)
        tcs_pkg::TCS_ADDR, tcs_pkg::TCS_WPTR, tcs_pkg::TCS_WDATA: begin
          if (scl_rise) begin
            d.shreg = {q.shreg[6:0], q.sda_s2};
            d.cnt   = q.cnt + 3'd1;
            if (q.cnt == 3'd7) begin
              d.done = 1'b1;
            end
          end else if (scl_fall && q.done) begin
            d.done     = 1'b0;
            d.ack_from = q.state;
            d.state    = tcs_pkg::TCS_ACK;
            d.sda_drv  = 1'b1;
            if (q.state == tcs_pkg::TCS_ADDR) begin
              d.sel_diag = q.shreg[1];
              d.rd       = q.shreg[0];
              if (q.shreg[7:1] != tcs_pkg::DEV_ADDR_ID &&
                  q.shreg[7:1] != tcs_pkg::DEV_ADDR_DIAG) begin
                d.state   = tcs_pkg::TCS_IDLE;
                d.sda_drv = 1'b0;
              end
            end else if (q.state == tcs_pkg::TCS_WPTR) begin
              d.ptr = q.shreg;
            end else begin
              if (q.sel_diag && q.ptr == tcs_pkg::DIAG_CTRL_OFS) begin
                d.wr_pend = 1'b1;
                d.wr_val  = q.shreg[tcs_pkg::BIT_SOFT_DIS];
              end
              d.ptr = q.ptr + 8'h01;
            end
          end
        end
        tcs_pkg::TCS_ACK: begin
          // Acknowledge is released after the clock falls
          if (scl_fall) begin
            d.sda_drv = 1'b0;
            d.cnt     = 3'd0;
            case (q.ack_from)
              tcs_pkg::TCS_ADDR: begin
                if (q.rd) begin
                  d.shreg   = rd_byte(q.sel_diag, q.ptr, status);
                  d.sda_drv = ~d.shreg[7];
                  d.state   = tcs_pkg::TCS_RDATA;
                end else begin
                  d.state = tcs_pkg::TCS_WPTR;
                end
              end
              default: begin
                d.state = tcs_pkg::TCS_WDATA;
              end
            endcase
          end
        end
        tcs_pkg::TCS_RDATA: begin
          if (scl_rise) begin
            d.cnt = q.cnt + 3'd1;
            if (q.cnt == 3'd7) begin
              d.done = 1'b1;
            end
          end else if (scl_fall) begin
            if (q.done) begin
              d.done    = 1'b0;
              d.sda_drv = 1'b0;
              d.state   = tcs_pkg::TCS_MACK;
            end else begin
              d.shreg   = {q.shreg[6:0], 1'b0};
              d.sda_drv = ~q.shreg[6];
            end
          end
        end
        tcs_pkg::TCS_MACK: begin
          if (scl_rise) begin
            if (q.sda_s2) begin
              d.state = tcs_pkg::TCS_IDLE;
            end else begin
              d.done = 1'b1;
            end
          end else if (scl_fall && q.done) begin
            d.done    = 1'b0;
            d.cnt     = 3'd0;
            d.ptr     = q.ptr + 8'h01;
            d.shreg   = rd_byte(q.sel_diag, q.ptr + 8'h01, status);
            d.sda_drv = ~d.shreg[7];
            d.state   = tcs_pkg::TCS_RDATA;
          end
        end
        default: begin
          d.sda_drv = 1'b0;
          d.done    = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      q          <= '0;
      q.scl_s1   <= 1'b1;
      q.scl_s2   <= 1'b1;
      q.scl_s3   <= 1'b1;
      q.sda_s1   <= 1'b1;
      q.sda_s2   <= 1'b1;
      q.sda_s3   <= 1'b1;
      q.soft_dis <= tcs_pkg::SOFT_DIS_RST;
      q.state    <= tcs_pkg::TCS_IDLE;
      q.ack_from <= tcs_pkg::TCS_IDLE;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign laser_en_o     = q.laser_en;
  assign tx_fault_o     = q.fault;
  assign sig_det_o      = q.sig_s2;
  assign sda_o          = 1'b0;
  assign sda_oe_o       = ~q.sda_drv;
  assign serial_ready_o = q.init_done;

endmodule : tcs_xcvr_ctrl

// ---- logic/tcs_pkg.sv ----
package tcs_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned T_OFF_US       = 10;
  localparam int unsigned T_ON_MS        = 1;
  localparam int unsigned T_INIT_MS      = 300;
  localparam int unsigned T_RESET_US     = 10;
  localparam int unsigned T_LOSS_US      = 100;
  localparam int unsigned T_SOFT_MS      = 100;
  localparam int unsigned T_DATA_MS      = 1000;
  localparam int unsigned T_SERIAL_MS    = 300;
  localparam int unsigned T_WRITE_MS     = 10;
  localparam int unsigned F_SCL_MAX_KHZ  = 400;
  // Least hold time of the disable pin that clears a latched fault
  localparam int unsigned RESET_HOLD_CYC = T_RESET_US * CLK_MHZ;
  // Longest power-on time before serial access and data ready
  localparam int unsigned INIT_CYC_DEF   = T_SERIAL_MS * CLK_MHZ * 1000;

  // ------------------------------------------------------------------
  // Serial bus addresses and register map
  // ------------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR_ID    = 7'h50;
  localparam logic [6:0] DEV_ADDR_DIAG  = 7'h51;
  localparam logic [7:0] DIAG_CTRL_OFS  = 8'h6e;
  localparam int unsigned BIT_HARD_DIS  = 7;
  localparam int unsigned BIT_SOFT_DIS  = 6;
  localparam int unsigned BIT_FAULT     = 2;
  localparam int unsigned BIT_SIGDET    = 1;
  localparam int unsigned BIT_READY     = 0;
  localparam logic        SOFT_DIS_RST  = 1'b0;
  localparam logic [7:0]  UNMAPPED_DATA = 8'h00;

  // ------------------------------------------------------------------
  // Serial slave states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    TCS_IDLE,
    TCS_ADDR,
    TCS_WPTR,
    TCS_WDATA,
    TCS_ACK,
    TCS_RDATA,
    TCS_MACK
  } tcs_state_t;

endpackage : tcs_pkg

// ---- logic/tcs_hold_if.sv ----
interface tcs_hold_if;
  logic level;
  logic done;

  modport timer (
    input  level,
    output done
  );
  modport user (
    output level,
    input  done
  );
endinterface : tcs_hold_if

// ---- logic/tcs_hold_timer.sv ----
module tcs_hold_timer #(
  parameter int unsigned N = 16
) (
  // Clock and reset
  input wire logic   clk_sys_i,
  input wire logic   rst_n_i,
  // Level and its qualified form
  tcs_hold_if.timer  hold
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        done;
  } tcs_hold_st_t;

  tcs_hold_st_t q;
  tcs_hold_st_t d;

  // ------------------------------------------------------------------
  // Done rises once the level has stood high for N cycles
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    if (!hold.level) begin
      d.cnt  = 16'h0000;
      d.done = 1'b0;
    end else if (q.cnt == 16'(N - 1)) begin
      d.done = 1'b1;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hold.done = q.done;

endmodule : tcs_hold_timer

// ---- verification/tcs_xcvr_ctrl_assertions.sv ----
module tcs_xcvr_ctrl_chk #(
  parameter int unsigned INIT_CYC = tcs_pkg::INIT_CYC_DEF
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Pins
  input wire logic tx_disable_i,
  input wire logic laser_fault_i,
  input wire logic laser_en_o,
  input wire logic tx_fault_o,
  input wire logic rx_signal_i,
  input wire logic sig_det_o,
  // Serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic serial_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // Helper counters
  // ----------------
  logic [31:0] hold_q;
  logic [31:0] up_q;

  always_ff @(posedge clk_sys_i) begin
    hold_q <= tx_disable_i ? ((hold_q < 32'hffff) ? hold_q + 32'h1 : hold_q) : 32'h0;
    up_q   <= !rst_n_i ? 32'h0 : ((up_q < 32'hffffffff) ? up_q + 32'h1 : up_q);
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_pin_turns_off: assert property (tx_disable_i [*4] |=> !laser_en_o)
    else $error("laser on after disable pin");
  a_laser_needs_low: assert property (laser_en_o |-> !$past(tx_disable_i, 3))
    else $error("laser on while pin high");
  a_sig_rises: assert property (rx_signal_i [*4] |=> sig_det_o)
    else $error("signal presence not raised");
  a_sig_falls: assert property (!rx_signal_i [*4] |=> !sig_det_o)
    else $error("signal presence not dropped");
  a_fault_latches: assert property ((serial_ready_o && laser_fault_i) [*4] |=> tx_fault_o)
    else $error("fault not latched");
  a_fault_stands: assert property (tx_fault_o && !tx_disable_i && !$past(tx_disable_i, 4) |=> tx_fault_o)
    else $error("fault dropped without pin");
  a_fault_clear_hold: assert property ($fell(tx_fault_o) |-> hold_q >= tcs_pkg::RESET_HOLD_CYC)
    else $error("fault cleared by short hold");
  a_ready_not_early: assert property (serial_ready_o |-> up_q >= INIT_CYC - 2)
    else $error("ready too early");
  a_ready_in_time: assert property (up_q > INIT_CYC + 4 |-> serial_ready_o)
    else $error("ready too late");
  a_quiet_before_ready: assert property (!sda_oe_o |-> serial_ready_o)
    else $error("data line driven before ready");
  a_sda_moves_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line moved with clock high");
endmodule : tcs_xcvr_ctrl_chk

bind tcs_xcvr_ctrl tcs_xcvr_ctrl_chk #(.INIT_CYC(INIT_CYC)) u_tcs_xcvr_ctrl_chk (
  .clk_sys_i, .rst_n_i, .tx_disable_i, .laser_fault_i, .laser_en_o, .tx_fault_o,
  .rx_signal_i, .sig_det_o, .scl_i, .sda_i, .sda_o, .sda_oe_o, .serial_ready_o
);

// ---- verification/tcs_host_model.sv ----
module tcs_host_model #(
  parameter int unsigned Q = 80
) (
  // Clock
  input  wire logic clk_sys_i,
  // Device side of the data line
  input  wire logic sda_o,
  input  wire logic sda_oe_o,
  // Host drive
  output wire logic tx_disable_o,
  output wire logic scl_o,
  output wire logic sda_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dis_q = 1'b0;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;

  assign tx_disable_o = dis_q;
  assign scl_o        = scl_q;
  // Pull-up: the line is low while either party pulls it
  assign sda_line_o   = sda_q & (sda_oe_o | sda_o);

  // Quarter bit of Q cycles keeps the clock below 400 kHz
  task automatic step(input logic c, input logic d);
    scl_q = c;
    sda_q = d;
    repeat (Q) @(negedge clk_sys_i);
  endtask : step

  task automatic xbit(input logic b, output logic r);
    step(1'b0, b);
    step(1'b1, b);
    r = sda_line_o;
    step(1'b1, b);
    step(1'b0, b);
  endtask : xbit

  task automatic xbyte(input logic [7:0] d, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r[i]);
    end
    xbit(1'b1, ack);
  endtask : xbyte

  task automatic start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start

  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop

  task automatic reg_write(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
                           output logic nak);
    logic [7:0] r;
    logic [2:0] a;
    start();
    xbyte({dev, 1'b0}, r, a[0]);
    xbyte(p, r, a[1]);
    xbyte(d, r, a[2]);
    stop();
    nak = |a;
    repeat (8) @(negedge clk_sys_i);
  endtask : reg_write

  task automatic reg_read(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] d,
                          output logic nak);
    logic [7:0] r;
    logic [3:0] a;
    start();
    xbyte({dev, 1'b0}, r, a[0]);
    xbyte(p, r, a[1]);
    start();
    xbyte({dev, 1'b1}, r, a[2]);
    xbyte(8'hff, d, a[3]);
    stop();
    nak = |a[2:0];
  endtask : reg_read
endmodule : tcs_host_model

// ---- verification/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned INIT = 200;
  localparam logic [6:0] DIAG = tcs_pkg::DEV_ADDR_DIAG;
  localparam logic [7:0] OFS  = tcs_pkg::DIAG_CTRL_OFS;
  logic clk_sys_i   = 1'b0;
  logic rst_n_i     = 1'b0;
  logic laser_fault = 1'b0;
  logic rx_signal   = 1'b0;
  logic tx_disable, scl, sda, sda_o, sda_oe, laser_en, tx_fault, sig_det, ready;
  logic [7:0] d;
  logic nak;
  int n_mismatch = 0;
  int num_checks = 0;

  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  tcs_xcvr_ctrl #(.INIT_CYC(INIT)) u_tcs_xcvr_ctrl (
    .clk_sys_i     (clk_sys_i),
    .rst_n_i       (rst_n_i),
    .tx_disable_i  (tx_disable),
    .laser_fault_i (laser_fault),
    .laser_en_o    (laser_en),
    .tx_fault_o    (tx_fault),
    .rx_signal_i   (rx_signal),
    .sig_det_o     (sig_det),
    .scl_i         (scl),
    .sda_i         (sda),
    .sda_o         (sda_o),
    .sda_oe_o      (sda_oe),
    .serial_ready_o(ready)
  );

  tcs_host_model u_host (
    .clk_sys_i   (clk_sys_i),
    .sda_o       (sda_o),
    .sda_oe_o    (sda_oe),
    .tx_disable_o(tx_disable),
    .scl_o       (scl),
    .sda_line_o  (sda)
  );

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask : cyc

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic t_reset();
    int k;
    rst_n_i = 1'b0;
    cyc(2);
    chk(laser_en, 1'b0);
    chk(sda_oe, 1'b1);
    chk(sda_o, 1'b0);
    chk(ready, 1'b0);
    cyc(1);
    rst_n_i = 1'b1;
    cyc(INIT / 2);
    chk(ready, 1'b0);
    k = 0;
    while (ready !== 1'b1 && k < INIT) begin
      cyc(1);
      k++;
    end
    chk(ready, 1'b1);
    cyc(2);
    chk(laser_en, 1'b1);
  endtask : t_reset

  task automatic t_pin_sig();
    u_host.dis_q = 1'b1;
    rx_signal = 1'b1;
    cyc(5);
    chk(laser_en, 1'b0);
    chk(sig_det, 1'b1);
    u_host.reg_read(DIAG, OFS, d, nak);
    chk(nak, 1'b0);
    chk(d, 8'h83);
    u_host.dis_q = 1'b0;
    rx_signal = 1'b0;
    cyc(5);
    chk(laser_en, 1'b1);
    chk(sig_det, 1'b0);
    rx_signal = 1'b1;
  endtask : t_pin_sig

  task automatic t_fault();
    laser_fault = 1'b1;
    cyc(5);
    chk(tx_fault, 1'b1);
    laser_fault = 1'b0;
    u_host.reg_read(DIAG, OFS, d, nak);
    chk(d, 8'h07);
    u_host.dis_q = 1'b1;
    cyc(600);
    u_host.dis_q = 1'b0;
    cyc(5);
    chk(tx_fault, 1'b1);
    u_host.dis_q = 1'b1;
    cyc(1300);
    chk(tx_fault, 1'b0);
    u_host.dis_q = 1'b0;
    cyc(5);
    chk(laser_en, 1'b1);
  endtask : t_fault

  task automatic t_soft();
    u_host.reg_write(DIAG, OFS, 8'h40, nak);
    chk(nak, 1'b0);
    chk(laser_en, 1'b0);
    u_host.reg_read(DIAG, OFS, d, nak);
    chk(d, 8'h43);
    u_host.reg_write(DIAG, OFS, 8'h00, nak);
    chk(laser_en, 1'b1);
    u_host.reg_read(tcs_pkg::DEV_ADDR_ID, 8'h00, d, nak);
    chk(nak, 1'b0);
    chk(d, 8'h00);
    u_host.reg_write(7'h23, OFS, 8'h40, nak);
    chk(nak, 1'b1);
    chk(laser_en, 1'b1);
  endtask : t_soft

  initial begin
    t_reset();
    t_pin_sig();
    t_fault();
    t_soft();
    t_reset();
    report_and_stop();
  end

  initial begin
    repeat (90000) @(posedge clk_sys_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_top
